// File: rtl/dhb_regs.svh
// register offsets, field positions, reset values and state width of the dma handshake block
// assumes the plain register port with byte addresses and 32-bit data
`ifndef DHB_REGS_SVH
`define DHB_REGS_SVH
`define DHB_CTRL_OFS 8'h00
`define DHB_WAIT_OFS 8'h04
`define DHB_ADDR_OFS 8'h08
`define DHB_STAT_OFS 8'h0C
`define DHB_CTRL_EN 0
`define DHB_CTRL_MODE_LO 1
`define DHB_CTRL_MODE_HI 2
`define DHB_CTRL_WRITE 3
`define DHB_WAIT_WS_LO 0
`define DHB_WAIT_WS_HI 2
`define DHB_WAIT_IDLE 3
`define DHB_CTRL_RST 4'h0
`define DHB_WAIT_RST 4'h0
`define DHB_ADDR_RST 32'h0000_0000
`define DHB_ST_WIDTH 9
`endif

// File: rtl/dhb_pkg.sv
// types of the dma handshake block: modes and sequencer states
// assumes dhb_regs.svh is in the include path
package dhb_pkg;
  typedef enum logic [1:0] {
    DHB_PLAIN = 2'h0,
    DHB_EXT = 2'h1,
    DHB_PACED = 2'h2,
    DHB_RSVD = 2'h3
  } dhb_mode_e;
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_SETUP = 9'h002,
    S_GRANT = 9'h004,
    S_HOLD = 9'h008,
    S_REL = 9'h010,
    S_GAP = 9'h020,
    S_FLOAT = 9'h040,
    S_HOST = 9'h080,
    S_HRET = 9'h100
  } dhb_state_e;
endpackage

// File: rtl/dhb_top.sv
// dma handshake sequencer and memory interface three-state control, one channel
// assumes all pins are asynchronous to core_clk; handover and slave-cycle flags come from logic on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "dhb_regs.svh"

// Notes on behaviour
// - the memory interface pins float and are driven again on clock edges following the suspend input.
// - each bus-master or host handover cycle seen while the sequencer is idle floats and re-drives the interface the same way.
// - the interface is released before the host grant goes low and driven only after it is high again.
// - the data enable changes on clock edges in sync cycles as master or as slave, the acknowledge enable in slave cycles only.
// - three handshake modes exist and each transfer is started by the peripheral pulling its request low.
// - in plain handshake mode the grant alone tells the peripheral when to latch or drive data.
// - in external handshake mode address, strobes, selects, the held request and grant run each transfer.
// - in paced master mode address, strobes and selects run the transfer and the grant stays high.
// - in paced master mode each cycle follows the normal master protocol, extended while acknowledge is low.
// - the request is sampled on clock edges and a late request is taken one cycle later.
// - a write may be stalled by the peripheral holding its request low, with data after release.
// - a read is extended by one cycle for each extra cycle the request stays low.
// - the grant low phase is lengthened by the programmed wait states, one clock each.
// - with the idle option one extra clock separates grant high from the next strobe or grant.
// - on a handshake write the write strobe falls no later than the grant and rises one cycle before it.
// - on a handshake read the read strobe falls no later than the grant and rises with it.
module dhb_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // handshake and bus pins
  input wire logic dma_request_n,
  input wire logic suspend_bus_three_state_n,
  input wire logic host_bus_request_n,
  input wire logic ack_in,
  output logic dma_grant_n,
  output logic host_bus_grant_n,
  output logic rd_n,
  output logic wr_n,
  output logic [3:0] memory_select_n,
  output logic [31:0] addr_out,
  output logic mem_if_oe,
  output logic data_oe,
  output logic ack_out,
  output logic ack_oe,
  // core-side cycle flags
  input wire logic master_handover_cycle,
  input wire logic host_handover_cycle,
  input wire logic slave_sync_read,
  input wire logic slave_sync_access
);
  import dhb_pkg::*;

  typedef struct packed {
    logic [1:0] req_p, suspend_bus_three_state_n_p, host_p, ack_p;
    logic en;
    dhb_mode_e mode;
    logic dir_wr;
    logic [2:0] waits;
    logic idle;
    logic [31:0] ptr;
    logic [15:0] count;
    dhb_state_e st;
    logic [2:0] wcnt;
    logic [31:0] rdata;
    logic grant_n, hbg_n, rd_n, wr_n, msel_n, oe, doe, aoe;
  } dhb_state_s;

  dhb_state_s r, n;
  logic req_low, suspend_bus_three_state_n_low, host_low, ack_hi, float_req, stall, strobe, grant;

  always_comb begin
    n = r;
    // two-stage synchronisers, only the second stage is read
    n.req_p = {r.req_p[0], dma_request_n};
    n.suspend_bus_three_state_n_p = {r.suspend_bus_three_state_n_p[0], suspend_bus_three_state_n};
    n.host_p = {r.host_p[0], host_bus_request_n};
    n.ack_p = {r.ack_p[0], ack_in};
    req_low = !r.req_p[1];
    suspend_bus_three_state_n_low = !r.suspend_bus_three_state_n_p[1];
    host_low = !r.host_p[1];
    ack_hi = r.ack_p[1];
    float_req = suspend_bus_three_state_n_low | master_handover_cycle | host_handover_cycle | host_low;
    // paced cycles wait on acknowledge, handshake cycles on the held request
    stall = (r.mode == DHB_PACED) ? !ack_hi : req_low;
    n.rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `DHB_CTRL_OFS: n.rdata = {28'h000_0000, r.dir_wr, r.mode, r.en};
        `DHB_WAIT_OFS: n.rdata = {28'h000_0000, r.idle, r.waits};
        `DHB_ADDR_OFS: n.rdata = r.ptr;
        `DHB_STAT_OFS: n.rdata = {r.count, 7'h00, r.st};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `DHB_CTRL_OFS: begin
          n.en = reg_wdata[`DHB_CTRL_EN];
          n.mode = dhb_mode_e'(reg_wdata[`DHB_CTRL_MODE_HI:`DHB_CTRL_MODE_LO]);
          n.dir_wr = reg_wdata[`DHB_CTRL_WRITE];
        end
        `DHB_WAIT_OFS: begin
          n.waits = reg_wdata[`DHB_WAIT_WS_HI:`DHB_WAIT_WS_LO];
          n.idle = reg_wdata[`DHB_WAIT_IDLE];
        end
        `DHB_ADDR_OFS: n.ptr = reg_wdata;
        default: ;
      endcase
    end
    // a reserved mode code never starts a transfer
    unique case (r.st)
      S_IDLE: begin
        if (float_req) begin
          n.st = S_FLOAT;
        end else if (r.en && req_low && r.mode != DHB_RSVD) begin
          n.st = S_SETUP;
        end
      end
      S_SETUP: begin
        n.st = S_GRANT;
        n.wcnt = r.waits;
      end
      S_GRANT, S_HOLD: begin
        if (r.wcnt != 3'h0) begin
          n.wcnt = r.wcnt - 3'h1;
        end else if (stall) begin
          n.st = S_HOLD;
        end else if (r.dir_wr && r.mode == DHB_EXT) begin
          n.st = S_REL;
        end else begin
          n.st = r.idle ? S_GAP : S_IDLE;
          n.count = r.count + 16'h0001;
          n.ptr = r.ptr + 32'h0000_0001;
        end
      end
      S_REL: begin
        n.st = r.idle ? S_GAP : S_IDLE;
        n.count = r.count + 16'h0001;
        n.ptr = r.ptr + 32'h0000_0001;
      end
      S_GAP: n.st = S_IDLE;
      S_FLOAT: begin
        if (host_low) begin
          n.st = S_HOST;
        end else if (!float_req) begin
          n.st = S_IDLE;
        end
      end
      S_HOST: begin
        if (!host_low) begin
          n.st = S_HRET;
        end
      end
      S_HRET: n.st = S_IDLE;
      default: n.st = S_IDLE;
    endcase
    // outputs are registered from the next state so every pin except the three upper bank selects comes from a flip-flop
    strobe = (n.st == S_SETUP || n.st == S_GRANT || n.st == S_HOLD) && r.mode != DHB_PLAIN;
    grant = (n.st == S_GRANT || n.st == S_HOLD || n.st == S_REL) && r.mode != DHB_PACED;
    n.grant_n = !grant;
    n.rd_n = !(strobe && !r.dir_wr);
    n.wr_n = !(strobe && r.dir_wr);
    // one bank select follows the strobes; the upper banks are never used by this channel
    n.msel_n = !strobe;
    n.hbg_n = !(n.st == S_HOST);
    // suspend seen by the second synchroniser stage floats the pins whatever the state
    n.oe = !(n.st == S_FLOAT || n.st == S_HOST || n.st == S_HRET || suspend_bus_three_state_n_low);
    n.doe = (n.oe && strobe && r.dir_wr) || slave_sync_read;
    n.aoe = slave_sync_access;
    if (sys_rst) begin
      n = '0;
      n.req_p = 2'h3;
      n.suspend_bus_three_state_n_p = 2'h3;
      n.host_p = 2'h3;
      n.ack_p = 2'h3;
      n.mode = dhb_mode_e'(2'(`DHB_CTRL_RST >> `DHB_CTRL_MODE_LO));
      n.ptr = `DHB_ADDR_RST;
      n.st = S_IDLE;
      n.grant_n = 1'b1;
      n.hbg_n = 1'b1;
      n.rd_n = 1'b1;
      n.wr_n = 1'b1;
      n.msel_n = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    r <= n;
  end

  assign reg_rdata = r.rdata;
  assign dma_grant_n = r.grant_n;
  assign host_bus_grant_n = r.hbg_n;
  assign rd_n = r.rd_n;
  assign wr_n = r.wr_n;
  assign memory_select_n = {3'h7, r.msel_n};
  assign addr_out = r.ptr;
  assign mem_if_oe = r.oe;
  assign data_oe = r.doe;
  assign ack_out = r.oe;
  assign ack_oe = r.aoe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence grant_fall;
    $fell(dma_grant_n);
  endsequence
  sequence host_rise;
    $rose(host_bus_grant_n);
  endsequence
  // grant release edge; then the first step of a host handover: request seen while the sequencer is idle
  sequence grant_rise;
    $rose(dma_grant_n);
  endsequence
  sequence host_req_seen;
    (r.st == S_IDLE && !r.host_p[1]);
  endsequence

  a_hbg_after_float: assert property ($fell(host_bus_grant_n) |-> !mem_if_oe && !$past(mem_if_oe))
    else $error("host grant low while interface driven");
  a_redrive_after_hbg: assert property (host_rise |-> !mem_if_oe)
    else $error("interface driven with host grant edge");
  a_suspend_float: assert property (!r.suspend_bus_three_state_n_p[1] |=> !mem_if_oe)
    else $error("interface driven during suspend");
  a_handover_float: assert property ((master_handover_cycle && r.st == S_IDLE) |=> !mem_if_oe)
    else $error("handover did not float interface");
  a_paced_no_grant: assert property ((r.mode == DHB_PACED) |=> (dma_grant_n || $past(r.mode) != DHB_PACED))
    else $error("grant asserted in paced mode");
  a_plain_no_strobe: assert property ((r.mode == DHB_PLAIN && $stable(r.mode)) |=> rd_n && wr_n)
    else $error("strobe in plain handshake mode");
  a_wr_before_grant: assert property (grant_fall |-> (r.mode != DHB_EXT || !r.dir_wr || !wr_n))
    else $error("write strobe late against grant");
  a_wr_rise_first: assert property ($rose(wr_n) && r.mode == DHB_EXT |-> !dma_grant_n ##1 dma_grant_n)
    else $error("write strobe not ahead of grant release");
  a_rd_with_grant: assert property ($rose(dma_grant_n) && !r.dir_wr && r.mode == DHB_EXT |-> rd_n)
    else $error("read strobe outlives grant");
  a_wait_length: assert property ((grant_fall and (r.wcnt == 3'h2 && r.ack_p[1] && r.req_p[1]))
    |-> !dma_grant_n [*3])
    else $error("grant shorter than wait states");
  a_read_extend: assert property ((r.st == S_GRANT && r.wcnt == 3'h0 && !r.req_p[1] && r.mode == DHB_EXT)
    |=> !dma_grant_n)
    else $error("held request did not extend access");
  a_idle_gap: assert property ((r.st == S_GAP) |-> ##1 (dma_grant_n && rd_n && wr_n))
    else $error("strobe during idle cycle");
  a_slave_ack_oe: assert property (slave_sync_access |=> ack_oe)
    else $error("acknowledge enable missed slave cycle");
  a_req_sampled: assert property ((r.st == S_IDLE && r.en && !r.req_p[1] && !float_req
    && r.mode != DHB_RSVD) |=> r.st == S_SETUP)
    else $error("sampled request not taken");
  a_paced_ack: assert property ((r.st == S_HOLD && r.mode == DHB_PACED && !r.ack_p[1]) |=> r.st == S_HOLD)
    else $error("paced cycle ended without acknowledge");

  // select, strobe and grant ordering on every transfer
  a_msel_strobe: assert property (memory_select_n == {3'h7, rd_n & wr_n})
    else $error("select does not follow strobes");
  a_rd_before_grant: assert property (grant_fall |-> (r.mode != DHB_EXT || r.dir_wr || !rd_n))
    else $error("read strobe late against grant");
  a_plain_grant: assert property ((r.st == S_SETUP && r.mode == DHB_PLAIN) |=> !dma_grant_n)
    else $error("grant missing in plain handshake");
  a_ext_strobe_lead: assert property ((r.st == S_SETUP && r.mode == DHB_EXT && $stable(r.mode))
    |-> (rd_n ^ wr_n) && dma_grant_n)
    else $error("external handshake strobe not ahead of grant");
  a_paced_strobe: assert property ((r.st == S_SETUP && r.mode == DHB_PACED && $stable(r.mode))
    |-> (rd_n ^ wr_n) && dma_grant_n)
    else $error("paced cycle without strobe");
  a_idle_quiet: assert property ((r.st == S_IDLE) |-> (dma_grant_n && rd_n && wr_n))
    else $error("strobe or grant low while idle");
  // wait states, stall and idle cycle
  a_wait_count: assert property ((r.st == S_GRANT && r.wcnt != 3'h0)
    |=> (r.st == S_GRANT && r.wcnt == $past(r.wcnt) - 3'h1))
    else $error("wait state not counted down");
  a_hold_extend: assert property ((r.st == S_HOLD && r.mode != DHB_PACED && !r.req_p[1])
    |=> (r.st == S_HOLD && !dma_grant_n))
    else $error("held request did not hold grant");
  a_idle_spacing: assert property ((grant_rise and (r.st == S_GAP)) |=> (dma_grant_n && rd_n && wr_n))
    else $error("idle cycle cut short");
  // enables in slave and master data cycles
  a_slave_doe: assert property (slave_sync_read |=> data_oe)
    else $error("data enable missed slave read");
  a_write_doe: assert property ((r.st == S_GRANT && r.mode == DHB_EXT && r.dir_wr && mem_if_oe
    && $stable(r.mode) && $stable(r.dir_wr)) |-> data_oe)
    else $error("data not driven in write strobe phase");
  // float, host grant and redrive steps
  a_host_float: assert property (host_req_seen |=> (!mem_if_oe && host_bus_grant_n))
    else $error("host request did not float interface first");
  a_host_entry: assert property ((r.st == S_FLOAT && !r.host_p[1]) |=> !host_bus_grant_n)
    else $error("host grant not given after float");
  a_hbg_low_float: assert property (!host_bus_grant_n |-> !mem_if_oe)
    else $error("interface driven under host grant");
  a_host_leave: assert property ((r.st == S_HOST && r.host_p[1]) |=> (host_bus_grant_n && !mem_if_oe))
    else $error("host grant release not ahead of redrive");
  a_hret_redrive: assert property ((r.st == S_HRET && r.suspend_bus_three_state_n_p[1]) |=> mem_if_oe)
    else $error("interface not driven after host grant high");
  a_float_release: assert property ((r.st == S_FLOAT && !float_req) |=> mem_if_oe)
    else $error("interface not driven after float ended");
endmodule
`default_nettype wire

// File: testbench/dhb_periph.sv
// partner model: peripheral that raises dma requests and paces with ack
// assumes its inputs change right after the rising edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module dhb_periph (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // commands from the bench
  input wire logic start,
  input wire logic [3:0] hold,
  input wire logic ack_stall,
  // pins toward the device
  output logic dma_request_n,
  output logic ack_in
);
  logic [4:0] left_r;
  // request low for 1+hold cycles; a longer hold stalls completion
  always_ff @(posedge core_clk) begin
    if (sys_rst) left_r <= 5'h00;
    else if (start) left_r <= {1'b0, hold} + 5'h01;
    else if (left_r != 5'h00) left_r <= left_r - 5'h01;
  end
  assign dma_request_n = (left_r == 5'h00);
  assign ack_in = ~ack_stall;
endmodule
`default_nettype wire

// File: testbench/dhb_top_bench.sv
// bench of the dma handshake block: random transfers in the three handshake modes, floats, host grant
// assumes dhb_periph on the request and ack pins
`timescale 1ns/1ps
`default_nettype none
module dhb_top_bench;
  import dhb_pkg::*;
  logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, start = 0, ack_stall = 0;
  logic suspend_bus_three_state_n = 1, host_bus_request_n = 1, master_handover_cycle = 0;
  logic host_handover_cycle = 0, slave_sync_read = 0, slave_sync_access = 0, dir, idl;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, addr_out, d;
  logic [3:0] hold = 4'h0, memory_select_n;
  logic dma_request_n, ack_in, dma_grant_n, host_bus_grant_n, rd_n, wr_n, mem_if_oe, data_oe, ack_out, ack_oe;
  logic [2:0] ws;
  dhb_mode_e md;
  int bad_count = 0, comparisons = 0, glow, slow, olow, dcnt, acnt, mcnt, it, k;
  always #2.5 core_clk = ~core_clk;
  dhb_periph u_dhb_periph (.core_clk, .sys_rst, .start, .hold, .ack_stall, .dma_request_n, .ack_in);
  dhb_top u_dhb_top (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .dma_request_n, .suspend_bus_three_state_n, .host_bus_request_n, .ack_in, .dma_grant_n,
    .host_bus_grant_n, .rd_n, .wr_n, .memory_select_n, .addr_out, .mem_if_oe, .data_oe, .ack_out,
    .ack_oe, .master_handover_cycle, .host_handover_cycle, .slave_sync_read, .slave_sync_access);
  task give_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // counts low cycles of grant, strobes and interface enable over n cycles
  task watch(input int n);
    glow = 0; slow = 0; olow = 0; dcnt = 0; acnt = 0; mcnt = 0;
    for (k = 0; k < n; k++) begin
      @(posedge core_clk);
      start <= 1'b0;
      slave_sync_read <= 1'b0;
      slave_sync_access <= 1'b0;
      master_handover_cycle <= 1'b0;
      host_handover_cycle <= 1'b0;
      ack_stall <= (md == DHB_PACED) && (k < 8) && dir;
      #1 glow += (dma_grant_n === 1'b0);
      slow += (rd_n === 1'b0 || wr_n === 1'b0);
      olow += (mem_if_oe === 1'b0);
      dcnt += (data_oe === 1'b1);
      acnt += (ack_oe === 1'b1);
      mcnt += (memory_select_n !== {3'h7, rd_n & wr_n} || ack_out !== mem_if_oe);
    end
  endtask
  task hbg_wait(input logic want);
    for (k = 0; k < 30 && host_bus_grant_n !== want; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (host_bus_grant_n !== want) begin
      bad_count++;
      give_verdict();
    end
  endtask
  initial begin
    void'($urandom(18642));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h10); chk(d, 32'h0000_0000);
    for (it = 0; it < 12; it++) begin
      md = dhb_mode_e'(it % 3);
      ws = 3'($urandom % 8);
      {idl, dir} = 2'($urandom % 4);
      wr(8'h04, {28'h0, idl, ws});
      wr(8'h00, {28'h0, dir, md, 1'b1});
      @(posedge core_clk) start <= 1'b1;
      watch(40);
      chk(glow, md == DHB_PACED ? 0 : ((md == DHB_EXT && dir) ? 2 + ws : 1 + ws));
      if (md == DHB_PACED) chk(slow > 0, 1);
      else chk(slow, md == DHB_PLAIN ? 0 : 2 + ws);
      chk(mcnt, 0);
      rd(8'h0C); chk(d[31:16], it + 1);
    end
    chk(addr_out, 32'h0000_000C);
    md = DHB_EXT;
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0003);
    hold <= 4'h3;
    @(posedge core_clk) start <= 1'b1;
    watch(30);
    chk(glow, 3);
    @(posedge core_clk) suspend_bus_three_state_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(mem_if_oe, 1'b0);
    @(posedge core_clk) suspend_bus_three_state_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk(mem_if_oe, 1'b1);
    for (it = 0; it < 2; it++) begin
      @(posedge core_clk) {master_handover_cycle, host_handover_cycle} <= it ? 2'b01 : 2'b10;
      watch(8);
      chk(olow > 0 && mem_if_oe === 1'b1, 1);
    end
    @(posedge core_clk) {slave_sync_read, slave_sync_access} <= 2'b11;
    watch(5);
    chk({dcnt[3:0], acnt[3:0]}, 8'h11);
    @(posedge core_clk) host_bus_request_n <= 1'b0;
    hbg_wait(1'b0);
    chk(mem_if_oe, 1'b0);
    @(posedge core_clk) host_bus_request_n <= 1'b1;
    hbg_wait(1'b1);
    chk(mem_if_oe, 1'b0);
    repeat (3) @(posedge core_clk);
    #1 chk(mem_if_oe, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
